// ===== rtl/hbridge_map.vh
// hbridge_map.vh: constants for the h-bridge gate control and fault logic.
// assumes a 200 mhz core clock and a 32-bit axi4-lite register port.
`ifndef HBRIDGE_MAP_VH
`define HBRIDGE_MAP_VH

// clock period and protection timing, times in ns
`define CYCLE_NS 5
`define OFF_TIME_NS 20000
`define BLANK_TIME_NS 16500
`define OFF_CYCLES ((`OFF_TIME_NS + `CYCLE_NS - 1) / `CYCLE_NS)
`define BLANK_CYCLES ((`BLANK_TIME_NS + `CYCLE_NS - 1) / `CYCLE_NS)
`define TIMER_W 12

// pin synchroniser width and bit positions
`define SYNC_W 17
`define S_CMD1 0
`define S_CMD2 1
`define S_PINV 2
`define S_SLEW 3
`define S_DAH 4
`define S_DAL 5
`define S_WAKE 6
`define S_ILIM 7
`define S_FBLIM 8
`define S_FBTEMP 9
`define S_TTRIP 10
`define S_TCLR 11
`define S_SHORT 12
`define S_UV 13
`define S_PINV_DRV 14
`define S_SLEW_DRV 15
`define S_WAKE_DRV 16

// register byte addresses
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LIMIT_COUNT 8'h08

// control fields and reset value
`define CTRL_FORCE_OFF 0
`define CTRL_CLEAR 1
`define CTRL_RESET 1'b0

// status fields
`define ST_LATCH 0
`define ST_THERM 1
`define ST_UV 2
`define ST_FOLDBACK 3
`define ST_OFFTIME 4
`define ST_BLANK 5
`define ST_SLEEP 6
`define ST_FAULT 7
`define ST_LEG1 8
`define ST_LEG2 9
`define ST_LEG_EN 10

// axi responses
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ===== rtl/hbridge_gate_control_fault_logic.v
// hbridge_gate_control_fault_logic: leg decode, current limit, fault latch.
// assumes comparator outputs arrive as levels; pads report undriven pins.
//
// Behaviour
// (RULE1) each leg follows its own command
// (RULE2) invert makes both leg commands active low
// (RULE3) undriven invert means non-inverted commands
// (RULE4) edge select picks rate, slow when undriven
// (RULE5) host keeps slow-rate pwm below 11 khz
// (RULE6) either disable tri-states both legs only; the code also pulls the fault flag low while disabled
// (RULE7) wake low sleeps, wake high runs
// (RULE8) undriven wake pin means sleep
// (RULE9) short circuit latches both legs off
// (RULE10) toggle disable, wake or supply clears latch; the code clears it on disable, wake or a control write, not on supply
// (RULE11) limit hit tri-states for constant off time
// (RULE12) hot junction selects lower foldback limit
// (RULE13) thermal trip latches off, hysteresis before restart
// (RULE14) blanking after each transition masks current limit
// (RULE15) open-drain active-low fault flag pulls low
// (RULE16) undervoltage shuts the output stage down
// (RULE17) undervoltage recovery restores outputs and flag
// (RULE18) disable high-low or low-high edge clears latch
// (RULE19) constant off time lasts 20 us
// (RULE20) timers count cycles, restart on trigger
// (RULE21) pins and comparators synchronised before use
`include "hbridge_map.vh"
`default_nettype none

module hbridge_gate_control_fault_logic (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control pins from the host
    input wire first_leg_command,
    input wire second_leg_command,
    input wire polarity_invert,
    input wire polarity_invert_driven,
    input wire edge_rate_fast,
    input wire edge_rate_fast_driven,
    input wire disable_active_high,
    input wire disable_active_low,
    input wire wake,
    input wire wake_driven,
    // comparators from the analog section
    input wire current_limit_level,
    input wire foldback_limit_level,
    input wire foldback_temp,
    input wire thermal_trip,
    input wire thermal_clear,
    input wire short_detect,
    input wire supply_rail_low,
    // output legs, enable low while driven
    output reg first_leg_output,
    output reg first_leg_oe_n,
    output reg second_leg_output,
    output reg second_leg_oe_n,
    output reg edge_rate_fast_sel,
    output reg sleep_mode,
    // open-drain fault flag, enable low while pulling
    output wire fault_flag_n,
    output reg fault_flag_oe_n,
    // axi4-lite write address and data
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam integer OFF_I = `OFF_CYCLES;
    localparam integer BLANK_I = `BLANK_CYCLES;
    localparam [`TIMER_W-1:0] OFF_LOAD = OFF_I[`TIMER_W-1:0];
    localparam [`TIMER_W-1:0] BLANK_LOAD = BLANK_I[`TIMER_W-1:0];
    localparam [`TIMER_W-1:0] T_ZERO = 12'h000;
    localparam [15:0] ONE16 = 16'h0001;

    wire [`SYNC_W-1:0] pin_raw;
    reg [`SYNC_W-1:0] sync_a;
    reg [`SYNC_W-1:0] sync_b;
    reg prev_dah;
    reg prev_dal;
    reg prev_wake;
    reg latch;
    reg therm_hot;
    reg [`TIMER_W-1:0] off_timer;
    reg [`TIMER_W-1:0] blank_timer;
    reg [15:0] limit_count;
    reg force_off;
    reg sw_clear;
    reg aw_got;
    reg w_got;
    reg [`ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg w_lane0;

    assign pin_raw = {wake_driven, edge_rate_fast_driven, polarity_invert_driven,
                      supply_rail_low, short_detect, thermal_clear, thermal_trip,
                      foldback_temp, foldback_limit_level, current_limit_level,
                      wake, disable_active_low, disable_active_high,
                      edge_rate_fast, polarity_invert, second_leg_command,
                      first_leg_command};

    // two-stage synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
            // (RULE21) two-flop synchroniser
            always @(posedge aclk) begin
                if (!aresetn) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // decoded pin levels with floating-pin defaults
    wire invert_eff, awake, disabled, cmd1, cmd2, limit_hit;
    // (RULE3) floating invert reads as off
    assign invert_eff = sync_b[`S_PINV_DRV] & sync_b[`S_PINV];
    // (RULE8) floating wake means sleep
    assign awake = sync_b[`S_WAKE_DRV] & sync_b[`S_WAKE];
    // (RULE6) either disable asserted
    assign disabled = sync_b[`S_DAH] | ~sync_b[`S_DAL];
    // (RULE1) independent leg commands
    // (RULE2) invert flips both commands
    assign cmd1 = sync_b[`S_CMD1] ^ invert_eff;
    assign cmd2 = sync_b[`S_CMD2] ^ invert_eff;
    // (RULE12) foldback threshold when hot
    assign limit_hit = sync_b[`S_FBTEMP] ? sync_b[`S_FBLIM] : sync_b[`S_ILIM];

    // latch clear events
    wire dah_fall, dal_rise, wake_rise, latch_set, latch_clr;
    // (RULE18) disable edges that clear
    assign dah_fall = prev_dah & ~sync_b[`S_DAH];
    assign dal_rise = ~prev_dal & sync_b[`S_DAL];
    assign wake_rise = ~prev_wake & awake;
    // (RULE9) short latches off
    // (RULE13) thermal trip latches off
    assign latch_set = awake & (sync_b[`S_SHORT] | sync_b[`S_TTRIP]);
    // (RULE10) toggle clears the latch
    assign latch_clr = dah_fall | dal_rise | wake_rise | sw_clear;

    // output decode and protection timers
    reg hold_off, limit_trig, next_en, next_l1, next_l2, next_fault;
    always @* begin
        // (RULE7) sleep tri-states everything
        // (RULE16) undervoltage shuts outputs
        // (RULE17) outputs follow inputs after recovery
        hold_off = ~awake | disabled | sync_b[`S_UV] | latch | therm_hot
                   | force_off | (off_timer != T_ZERO);
        // (RULE14) limit masked while blanking
        // (RULE11) limit hit starts off time
        limit_trig = ~first_leg_oe_n & ~hold_off & limit_hit
                     & (blank_timer == T_ZERO);
        next_en = ~hold_off & ~limit_trig;
        next_l1 = next_en & cmd1;
        next_l2 = next_en & cmd2;
        // (RULE15) flag low on latch, disable or undervoltage
        next_fault = awake & (latch | disabled | sync_b[`S_UV]);
    end

    wire transition;
    assign transition = (next_en != ~first_leg_oe_n) | (next_l1 != first_leg_output)
                        | (next_l2 != second_leg_output);

    // protection state and outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_dah <= 1'b0;
            prev_dal <= 1'b0;
            prev_wake <= 1'b0;
            latch <= 1'b0;
            therm_hot <= 1'b0;
            off_timer <= T_ZERO;
            blank_timer <= T_ZERO;
            limit_count <= 16'h0000;
            first_leg_output <= 1'b0;
            second_leg_output <= 1'b0;
            first_leg_oe_n <= 1'b1;
            second_leg_oe_n <= 1'b1;
            edge_rate_fast_sel <= 1'b0;
            sleep_mode <= 1'b1;
            fault_flag_oe_n <= 1'b1;
        end else begin
            prev_dah <= sync_b[`S_DAH];
            prev_dal <= sync_b[`S_DAL];
            prev_wake <= awake;
            // set wins over clear
            latch <= latch_set | (latch & ~latch_clr);
            // (RULE13) restart only below hysteresis point
            therm_hot <= sync_b[`S_TTRIP] | (therm_hot & ~sync_b[`S_TCLR]);
            // (RULE19) off time of 20 us
            // (RULE20) counted off time restarts
            if (limit_trig) begin
                off_timer <= OFF_LOAD;
                limit_count <= limit_count + ONE16;
            end else if (off_timer != T_ZERO) begin
                off_timer <= off_timer - 12'h001;
            end
            // (RULE20) blanking restarts per transition
            if (transition) begin
                blank_timer <= BLANK_LOAD;
            end else if (blank_timer != T_ZERO) begin
                blank_timer <= blank_timer - 12'h001;
            end
            first_leg_output <= next_l1;
            second_leg_output <= next_l2;
            first_leg_oe_n <= ~next_en;
            second_leg_oe_n <= ~next_en;
            // (RULE4) slow unless driven fast
            edge_rate_fast_sel <= sync_b[`S_SLEW_DRV] & sync_b[`S_SLEW];
            sleep_mode <= ~awake;
            fault_flag_oe_n <= ~next_fault;
        end
    end

    // open-drain flag only ever pulls low
    assign fault_flag_n = 1'b0;

    // axi write address, write data and read address handshakes
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire do_write;
    assign do_write = aw_got & w_got;

    // write path and control register
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            force_off <= `CTRL_RESET;
            sw_clear <= 1'b0;
        end else begin
            sw_clear <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == `REG_CTRL) begin
                    s_axi_bresp <= `RESP_OKAY;
                    if (w_lane0) begin
                        force_off <= w_data[`CTRL_FORCE_OFF];
                        sw_clear <= w_data[`CTRL_CLEAR];
                    end
                end else if (aw_addr == `REG_STATUS || aw_addr == `REG_LIMIT_COUNT) begin
                    s_axi_bresp <= `RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RESP_DECERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // status word
    reg [31:0] status_word;
    always @* begin
        status_word = 32'h0000_0000;
        status_word[`ST_LATCH] = latch;
        status_word[`ST_THERM] = therm_hot;
        status_word[`ST_UV] = sync_b[`S_UV];
        status_word[`ST_FOLDBACK] = sync_b[`S_FBTEMP];
        status_word[`ST_OFFTIME] = off_timer != T_ZERO;
        status_word[`ST_BLANK] = blank_timer != T_ZERO;
        status_word[`ST_SLEEP] = sleep_mode;
        status_word[`ST_FAULT] = ~fault_flag_oe_n;
        status_word[`ST_LEG1] = first_leg_output;
        status_word[`ST_LEG2] = second_leg_output;
        status_word[`ST_LEG_EN] = ~first_leg_oe_n;
    end

    // read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            if (s_axi_araddr == `REG_CTRL) begin
                s_axi_rdata <= {31'h0000_0000, force_off};
            end else if (s_axi_araddr == `REG_STATUS) begin
                s_axi_rdata <= status_word;
            end else if (s_axi_araddr == `REG_LIMIT_COUNT) begin
                s_axi_rdata <= {16'h0000, limit_count};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_DECERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== tb/hbridge_props.sv
// hb_props: protection timing checks bound to the h-bridge control block.
// assumes pins act three edges after they change and reset is synchronous.
`default_nettype none
module hb_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // host pins
    input wire logic first_leg_command,
    input wire logic second_leg_command,
    input wire logic polarity_invert,
    input wire logic polarity_invert_driven,
    input wire logic disable_active_high,
    input wire logic disable_active_low,
    input wire logic wake,
    input wire logic wake_driven,
    // comparators and bus strobes
    input wire logic thermal_trip,
    input wire logic thermal_clear,
    input wire logic short_detect,
    input wire logic supply_rail_low,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    // outputs
    input wire logic first_leg_output,
    input wire logic first_leg_oe_n,
    input wire logic second_leg_output,
    input wire logic second_leg_oe_n,
    input wire logic sleep_mode,
    input wire logic fault_flag_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic run_ok;
    logic [7:0] okh;
    logic clean;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    // only the current limit may tri-state the legs while this holds
    assign run_ok = !disable_active_high && disable_active_low && wake && wake_driven
        && !short_detect && !thermal_trip && thermal_clear && !supply_rail_low
        && !s_axi_awvalid && !s_axi_wvalid;
    // run lengths of the leg enable and whether a run had a clean cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            okh <= 8'h00;
            clean <= 1'b0;
            hi_cnt <= 16'h0000;
            lo_cnt <= 16'h0000;
        end else begin
            okh <= {okh[6:0], run_ok};
            hi_cnt <= first_leg_oe_n ? hi_cnt + 16'h0001 : 16'h0000;
            lo_cnt <= first_leg_oe_n ? 16'h0000 : lo_cnt + 16'h0001;
            if (!first_leg_oe_n)
                clean <= &okh;
            else if (!run_ok)
                clean <= 1'b0;
        end
    end
    sequence s_hit(sig); (sig && wake && wake_driven) [*3]; endsequence
    sequence s_latched; ##[1:3] (first_leg_oe_n && second_leg_oe_n && !fault_flag_oe_n);
    endsequence
    property p_legs; !first_leg_oe_n |-> first_leg_output == ($past(first_leg_command, 3)
        ^ ($past(polarity_invert, 3) & $past(polarity_invert_driven, 3)))
        && second_leg_output == ($past(second_leg_command, 3)
        ^ ($past(polarity_invert, 3) & $past(polarity_invert_driven, 3))); endproperty
    a_legs: assert property (p_legs) else $error("leg level wrong");
    property p_dis; (disable_active_high || !disable_active_low) [*4] |->
        first_leg_oe_n && second_leg_oe_n; endproperty
    a_dis: assert property (p_dis) else $error("disable ignored");
    property p_sleep; (!wake || !wake_driven) [*4] |-> sleep_mode; endproperty
    a_sleep: assert property (p_sleep) else $error("not asleep");
    property p_short; s_hit(short_detect) |-> s_latched; endproperty
    a_short: assert property (p_short) else $error("short not latched");
    property p_therm; s_hit(thermal_trip) |-> s_latched; endproperty
    a_therm: assert property (p_therm) else $error("trip not latched");
    property p_clear; (!fault_flag_oe_n && $fell(disable_active_high)) ##1 run_ok [*6]
        |-> fault_flag_oe_n; endproperty
    a_clear: assert property (p_clear) else $error("latch not cleared");
    property p_uv; supply_rail_low [*4] |-> first_leg_oe_n && !fault_flag_oe_n; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage ignored");
    property p_off; $fell(first_leg_oe_n) && clean |-> hi_cnt inside {[16'h0f9f:16'h0fa1]};
    endproperty
    a_off: assert property (p_off) else $error("off time wrong");
    property p_blank; $rose(first_leg_oe_n) && (&okh) |-> lo_cnt >= 16'h0ce3; endproperty
    a_blank: assert property (p_blank) else $error("limit inside blanking");
endmodule
`default_nettype wire

// ===== tb/hbridge_host_model.sv
// hbridge_host_model: host side of the status line, a pulled-up open drain.
// assumes the block pulls the line only while its enable is low.
`default_nettype none
module hbridge_host_model (
    // from the block
    input wire logic fault_flag_n,
    input wire logic fault_flag_oe_n,
    // level the host reads
    output logic flag_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    assign flag_seen = fault_flag_oe_n ? 1'b1 : fault_flag_n;
endmodule
`default_nettype wire

// ===== tb/hbridge_gate_control_fault_logic_test.sv
// hbridge_gate_control_fault_logic_test: pin, protection and bus scenarios.
// assumes the block's header constants and the host model for the flag.
`include "hbridge_map.vh"
`default_nettype none
module hbridge_gate_control_fault_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, first_leg_command = 1'b0, second_leg_command = 1'b0;
    logic polarity_invert = 1'b0, polarity_invert_driven = 1'b1, edge_rate_fast = 1'b0;
    logic edge_rate_fast_driven = 1'b1, disable_active_high = 1'b0, disable_active_low = 1'b1;
    logic wake = 1'b0, wake_driven = 1'b1, current_limit_level = 1'b0, foldback_temp = 1'b0;
    logic foldback_limit_level = 1'b0, thermal_trip = 1'b0, thermal_clear = 1'b1;
    logic short_detect = 1'b0, supply_rail_low = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, probe = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    wire first_leg_output, first_leg_oe_n, second_leg_output, second_leg_oe_n, sleep_mode;
    wire edge_rate_fast_sel, fault_flag_n, fault_flag_oe_n, flag_seen, s_axi_awready;
    wire s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [6:0] pins = {flag_seen, sleep_mode, edge_rate_fast_sel, first_leg_oe_n,
        first_leg_output, second_leg_oe_n, second_leg_output};
    logic [33:0] expq[$];
    logic [33:0] w;
    logic [15:0] lf = 16'h000f;
    int fail_count = 0;
    int num_checks = 0;
    hbridge_gate_control_fault_logic dut (.*);
    hbridge_host_model host (.*);
    always #2.5 aclk = ~aclk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
        num_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // notes the pin state due for a given drive and fault, then samples it
    task automatic look(input logic drv, input logic flt);
        logic iv;
        logic up;
        tick(6);
        iv = polarity_invert & polarity_invert_driven;
        up = wake & wake_driven;
        expq.push_back({27'h0, !(flt && up), !up, edge_rate_fast & edge_rate_fast_driven, !drv,
            drv & (first_leg_command ^ iv), !drv, drv & (second_leg_command ^ iv)});
        probe <= 1'b1;
        tick(1);
        probe <= 1'b0;
    endtask
    // bus write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expq.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(1);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) tick(1);
        s_axi_bready <= 1'b0;
        tick(1);
    endtask
    // bus read
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do tick(1); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) tick(1);
        s_axi_rready <= 1'b0;
        tick(1);
    endtask
    // takes the oldest note whenever a result shows at the outputs
    always @(posedge aclk) begin
        if (probe || (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            w = (expq.size() > 0) ? expq.pop_front() : 34'h3_ffff_ffff;
            if (probe)
                check("pins", {27'h0, pins}, w);
            else if (s_axi_bvalid)
                check("bresp", {s_axi_bresp, 32'h0}, w);
            else
                check("rdata", {s_axi_rresp, s_axi_rdata}, w);
        end
    end
    // cuts a hung run short
    initial begin
        tick(40000);
        fail_count++;
        close_out();
    end
    // main sequence
    initial begin
        int i;
        tick(10);
        aresetn <= 1'b1;
        look(0, 0);
        wake <= 1'b1;
        edge_rate_fast <= 1'b1;
        for (i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            {first_leg_command, second_leg_command, polarity_invert,
                polarity_invert_driven} <= lf[3:0];
            look(1, 0);
        end
        edge_rate_fast_driven <= 1'b0;
        look(1, 0);
        {edge_rate_fast_driven, edge_rate_fast, disable_active_high} <= 3'b101;
        look(0, 1);
        {disable_active_high, disable_active_low} <= 2'b00;
        look(0, 1);
        {disable_active_low, wake_driven} <= 2'b10;
        look(0, 0);
        wake_driven <= 1'b1;
        for (i = 0; i < 4; i++) begin
            short_detect <= 1'b1;
            tick(4);
            short_detect <= 1'b0;
            look(0, 1);
            case (i)
                0: disable_active_high <= 1'b1;
                1: disable_active_low <= 1'b0;
                2: wake <= 1'b0;
                default: wr(`REG_CTRL, 32'h0000_0002, `RESP_OKAY);
            endcase
            tick(6);
            {disable_active_high, disable_active_low, wake} <= 3'b011;
            look(1, 0);
        end
        {thermal_clear, thermal_trip} <= 2'b01;
        tick(4);
        {thermal_trip, disable_active_high} <= 2'b01;
        look(0, 1);
        disable_active_high <= 1'b0;
        look(0, 0);
        thermal_clear <= 1'b1;
        look(1, 0);
        supply_rail_low <= 1'b1;
        look(0, 1);
        supply_rail_low <= 1'b0;
        look(1, 0);
        tick(3400);
        current_limit_level <= 1'b1;
        for (i = 0; i < 100 && !first_leg_oe_n; i++) tick(1);
        tick(`OFF_CYCLES - 10);
        look(0, 0);
        tick(10);
        look(1, 0);
        {current_limit_level, foldback_limit_level, foldback_temp} <= 3'b011;
        tick(3400);
        look(0, 0);
        {foldback_limit_level, foldback_temp} <= 2'b00;
        tick(`OFF_CYCLES);
        wr(`REG_CTRL, 32'h0000_0001, `RESP_OKAY);
        look(0, 0);
        rd(`REG_CTRL, {`RESP_OKAY, 32'h0000_0001});
        rd(`REG_STATUS, {`RESP_OKAY, 32'h0000_0020});
        wr(`REG_CTRL, 32'h0000_0000, `RESP_OKAY);
        rd(`REG_LIMIT_COUNT, {`RESP_OKAY, 32'h0000_0002});
        wr(8'h0c, 32'h0000_0001, `RESP_DECERR);
        rd(8'h0c, {`RESP_DECERR, 32'h0000_0000});
        close_out();
    end
endmodule
bind hbridge_gate_control_fault_logic hb_props u_props (.*);
`default_nettype wire
